// >>> tofr_map.vh
// Register offsets, field positions, reset values and codes of the result and host-engine registers
`ifndef TOFR_MAP_VH
`define TOFR_MAP_VH

// Register offsets on the internal register port
`define TOFR_OFF_XFER2 8'h05
`define TOFR_OFF_RDFMT 8'h07
`define TOFR_OFF_PHASE 8'h08
`define TOFR_OFF_AMP 8'h09
`define TOFR_OFF_TEMP 8'h0A

// Transaction-two register fields
`define TOFR_XFER2_CNT_MSB 23
`define TOFR_XFER2_CNT_LSB 22
`define TOFR_XFER2_RSV_MSB 21
`define TOFR_XFER2_RSV_LSB 16
`define TOFR_XFER2_RST 6'h08

// Read format and write byte register fields
`define TOFR_RDFMT_ALIGN_MSB 23
`define TOFR_RDFMT_ALIGN_LSB 20
`define TOFR_RDFMT_BSEL_MSB 19
`define TOFR_RDFMT_BSEL_LSB 18
`define TOFR_RDFMT_CNT1_MSB 17
`define TOFR_RDFMT_CNT1_LSB 16
`define TOFR_RDFMT_WBYTE_MSB 7
`define TOFR_RDFMT_WBYTE_LSB 0
`define TOFR_RDFMT_RST 24'h000000

// Phase register fields
`define TOFR_PH_CNT0 23
`define TOFR_PH_AMBOVL 22
`define TOFR_PH_MODF 21
`define TOFR_PH_VALID 20
`define TOFR_PH_CH_MSB 19
`define TOFR_PH_CH_LSB 18
`define TOFR_PH_DRIVE 17
`define TOFR_PH_OVF 16

// Amplitude register fields
`define TOFR_AMP_BIN_MSB 23
`define TOFR_AMP_BIN_LSB 20
`define TOFR_AMP_F2WRAP 19
`define TOFR_AMP_SIGOVL 18
`define TOFR_AMP_CNT_MSB 17
`define TOFR_AMP_CNT_LSB 16

// Temperature register fields
`define TOFR_TMP_DIE_MSB 23
`define TOFR_TMP_DIE_LSB 12
`define TOFR_TMP_AMB_MSB 11
`define TOFR_TMP_AMB_LSB 2
`define TOFR_TMP_CNT_MSB 1
`define TOFR_TMP_CNT_LSB 0

// Codes
`define TOFR_CNT_ONE 2'h0
`define TOFR_CNT_TWO 2'h1
`define TOFR_ALIGN_12B 4'h8
`define TOFR_RESULT_RST 24'h000000

`endif

// >>> tofr_byte_route.v
// Byte lane selection and external temperature alignment from the host read word
`timescale 1ns/1ps
`default_nettype none
`include "tofr_map.vh"

module tofr_byte_route (
	// Host engine read word
	input wire [31:0] read_word,
	// Selection and alignment controls
	input wire [1:0] byte_sel,
	input wire [3:0] align_cfg,
	input wire wide_enable,
	// Routed results
	output wire [7:0] read_byte,
	output wire [11:0] ext_temp,
	output wire align_error
);

	wire [7:0] lane [0:3];

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_lane
			assign lane[i] = read_word[8 * i + 7:8 * i];
		end
	endgenerate

	assign read_byte = lane[byte_sel]; // R04

	// Wide read only honours the one documented alignment code
	wire wide_ok = wide_enable && (align_cfg == `TOFR_ALIGN_12B);
	assign ext_temp = wide_ok ? read_word[15:4] : {4'h0, read_word[7:0]}; // R03 R22
	assign align_error = wide_enable && (align_cfg != `TOFR_ALIGN_12B); // R03

endmodule
`default_nettype wire

// >>> tofr_amb_cmp.v
// Ambient overload compare against the calibration point and threshold
`timescale 1ns/1ps
`default_nettype none

module tofr_amb_cmp (
	// Ambient inputs
	input wire [9:0] ambient_level_code,
	input wire [9:0] ambient_calibration_point,
	input wire [9:0] ambient_saturation_threshold,
	// Result
	output wire overload
);

	wire [10:0] diff;

	assign diff = {1'b0, ambient_level_code} - {1'b0, ambient_calibration_point};
	// Negative difference means darker than calibration, never an overload
	assign overload = !diff[10] && (diff[9:0] > ambient_saturation_threshold); // R21

endmodule
`default_nettype wire

// >>> tofr_regs.v
// Host-engine configuration and per-frame result registers
//
// How it works
// R01 - Second transfer count: code 0 one, 1 two
// R02 - Software keeps reserved transfer field at 08h
// R03 - Code 8 takes read bits 15:4
// R04 - Byte select routes one read byte
// R05 - First transfer count: code 0 one, 1 two
// R06 - Write byte sent as second write byte
// R07 - Five-bit frame counter split over three registers
// R08 - Phase bit 22 flags ambient saturation
// R09 - Bit 21 reports modulation frequency used
// R10 - Bit 20 low during calibration frames
// R11 - Bits 19:18 report emitter channel used
// R12 - Bit 17 reports drive current level
// R13 - Calibrated phase plus overflow bit
// R14 - Amplitude bits 23:20 hold range bin
// R15 - Bit 19 flags second frequency wrap
// R16 - Bit 18 flags signal saturation
// R17 - Amplitude bits 15:0 unsigned amplitude
// R18 - Temperature bits 23:12 die temperature code
// R19 - Temperature bits 11:2 ambient level
// R20 - Reserved bits outside the transfer field written and read zero
// R21 - Ambient overload when above threshold
// R22 - Wide enable chooses 8 or 12-bit read
// R23 - All results update together per frame
`timescale 1ns/1ps
`default_nettype none
`include "tofr_map.vh"

module tofr_regs (
	// Clock and reset
	input wire clk_sys,
	input wire srst,
	// Register port from the target interface engine
	input wire [7:0] reg_addr,
	input wire [23:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [23:0] reg_rdata,
	output reg reg_rd_valid,
	// Settings held in neighbouring registers
	input wire ext_temp_wide_enable,
	input wire [9:0] ambient_calibration_point,
	input wire [9:0] ambient_saturation_threshold,
	// Host engine controls
	output reg [1:0] first_xfer_byte_count,
	output reg [1:0] second_xfer_byte_count,
	output reg xfer_count_error,
	output reg [7:0] host_second_write_byte,
	// Host engine read data
	input wire [31:0] host_read_word,
	output reg [7:0] host_read_byte,
	output reg [11:0] ext_temp_value,
	output reg ext_temp_cfg_error,
	// Frame results from the processing pipeline
	input wire frame_done,
	input wire [15:0] frame_phase,
	input wire frame_phase_wrap,
	input wire second_freq_phase_wrap,
	input wire [15:0] signal_amplitude,
	input wire signal_overload_flag,
	input wire [3:0] range_bin_index,
	input wire modulation_freq_sel,
	input wire internal_leak_cal_frame,
	input wire emitter_leak_cal_frame,
	input wire [1:0] emitter_channel,
	input wire drive_current_level,
	input wire [11:0] die_temperature_code,
	input wire [9:0] ambient_level_code
);

	// Decoded address match, shared by the write and read paths
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// Byte count code to number of bytes; invalid codes fall back to one
	function [1:0] code_to_bytes;
		input [1:0] code;
		begin
			case (code)
				`TOFR_CNT_ONE: code_to_bytes = 2'h1;
				`TOFR_CNT_TWO: code_to_bytes = 2'h2;
				default: code_to_bytes = 2'h1;
			endcase
		end
	endfunction

	// Writable configuration
	reg [1:0] xfer2_cnt_r;
	reg [5:0] xfer2_rsv_r;
	reg [3:0] align_r;
	reg [1:0] bsel_r;
	reg [1:0] cnt1_r;
	reg [7:0] wbyte_r;

	// Frame result snapshot
	reg [15:0] phase_r;
	reg phase_ovf_r;
	reg amb_ovl_r;
	reg modf_r;
	reg valid_r;
	reg [1:0] chan_r;
	reg drive_r;
	reg [3:0] bin_r;
	reg f2wrap_r;
	reg sigovl_r;
	reg [15:0] amp_r;
	reg [11:0] die_r;
	reg [9:0] amb_r;
	reg [4:0] frame_cnt_r;

	// Assembled register images
	reg [23:0] xfer2_img;
	reg [23:0] rdfmt_img;
	reg [23:0] phase_img;
	reg [23:0] amp_img;
	reg [23:0] temp_img;
	reg [23:0] rdata_nxt;

	wire [7:0] route_byte;
	wire [11:0] route_temp;
	wire route_err;
	wire amb_overload;

	tofr_byte_route u_route (
		.read_word(host_read_word),
		.byte_sel(bsel_r),
		.align_cfg(align_r),
		.wide_enable(ext_temp_wide_enable),
		.read_byte(route_byte),
		.ext_temp(route_temp),
		.align_error(route_err)
	);

	tofr_amb_cmp u_amb (
		.ambient_level_code(ambient_level_code),
		.ambient_calibration_point(ambient_calibration_point),
		.ambient_saturation_threshold(ambient_saturation_threshold),
		.overload(amb_overload)
	);

	// Transaction-two configuration; result registers ignore writes
	always @(posedge clk_sys) begin
		if (srst) begin
			xfer2_cnt_r <= 2'h0;
			xfer2_rsv_r <= `TOFR_XFER2_RST; // R02
		end else if (reg_wr && hit(reg_addr, `TOFR_OFF_XFER2)) begin
			xfer2_cnt_r <= reg_wdata[`TOFR_XFER2_CNT_MSB:`TOFR_XFER2_CNT_LSB];
			// Stored as written; software is expected to keep 08h here
			xfer2_rsv_r <= reg_wdata[`TOFR_XFER2_RSV_MSB:`TOFR_XFER2_RSV_LSB]; // R02
		end
	end

	// Read format and write byte configuration
	always @(posedge clk_sys) begin
		if (srst) begin
			align_r <= 4'h0;
			bsel_r <= 2'h0;
			cnt1_r <= 2'h0;
			wbyte_r <= 8'h00;
		end else if (reg_wr && hit(reg_addr, `TOFR_OFF_RDFMT)) begin
			align_r <= reg_wdata[`TOFR_RDFMT_ALIGN_MSB:`TOFR_RDFMT_ALIGN_LSB];
			bsel_r <= reg_wdata[`TOFR_RDFMT_BSEL_MSB:`TOFR_RDFMT_BSEL_LSB];
			cnt1_r <= reg_wdata[`TOFR_RDFMT_CNT1_MSB:`TOFR_RDFMT_CNT1_LSB];
			wbyte_r <= reg_wdata[`TOFR_RDFMT_WBYTE_MSB:`TOFR_RDFMT_WBYTE_LSB];
		end
	end

	// Byte counts and their error, registered so every output is a flop
	always @(posedge clk_sys) begin
		if (srst) begin
			first_xfer_byte_count <= 2'h1;
			second_xfer_byte_count <= 2'h1;
			xfer_count_error <= 1'b0;
		end else begin
			first_xfer_byte_count <= code_to_bytes(cnt1_r); // R05
			second_xfer_byte_count <= code_to_bytes(xfer2_cnt_r); // R01
			xfer_count_error <= (xfer2_cnt_r > `TOFR_CNT_TWO) || (cnt1_r > `TOFR_CNT_TWO); // R01
		end
	end

	// Second write byte toward the host engine
	always @(posedge clk_sys) begin
		if (srst) begin
			host_second_write_byte <= 8'h00;
		end else begin
			host_second_write_byte <= wbyte_r; // R06
		end
	end

	// Selected read byte toward the host engine side
	always @(posedge clk_sys) begin
		if (srst) begin
			host_read_byte <= 8'h00;
		end else begin
			host_read_byte <= route_byte; // R04
		end
	end

	// External temperature and its alignment error
	always @(posedge clk_sys) begin
		if (srst) begin
			ext_temp_value <= 12'h000;
			ext_temp_cfg_error <= 1'b0;
		end else begin
			ext_temp_value <= route_temp; // R03 R22
			ext_temp_cfg_error <= route_err; // R03
		end
	end

	// Whole frame captured on one edge so a read never mixes two frames
	// Phase register fields
	always @(posedge clk_sys) begin
		if (srst) begin
			phase_r <= 16'h0000;
			phase_ovf_r <= 1'b0;
			amb_ovl_r <= 1'b0;
			modf_r <= 1'b0;
			valid_r <= 1'b0;
			chan_r <= 2'h0;
			drive_r <= 1'b0;
		end else if (frame_done) begin // R23
			phase_r <= frame_phase; // R13
			phase_ovf_r <= frame_phase_wrap; // R13
			amb_ovl_r <= amb_overload; // R08 R21
			modf_r <= modulation_freq_sel; // R09
			valid_r <= !(internal_leak_cal_frame || emitter_leak_cal_frame); // R10
			chan_r <= emitter_channel; // R11
			drive_r <= drive_current_level; // R12
		end
	end

	// Amplitude register fields, same strobe
	always @(posedge clk_sys) begin
		if (srst) begin
			bin_r <= 4'h0;
			f2wrap_r <= 1'b0;
			sigovl_r <= 1'b0;
			amp_r <= 16'h0000;
		end else if (frame_done) begin // R23
			bin_r <= range_bin_index; // R14
			f2wrap_r <= second_freq_phase_wrap; // R15
			sigovl_r <= signal_overload_flag; // R16
			amp_r <= signal_amplitude; // R17
		end
	end

	// Temperature register fields, same strobe
	always @(posedge clk_sys) begin
		if (srst) begin
			die_r <= 12'h000;
			amb_r <= 10'h000;
		end else if (frame_done) begin // R23
			die_r <= die_temperature_code; // R18
			amb_r <= ambient_level_code; // R19
		end
	end

	// Frame counter wraps modulo 32, as the five visible bits do
	always @(posedge clk_sys) begin
		if (srst) begin
			frame_cnt_r <= 5'h00;
		end else if (frame_done) begin // R23
			frame_cnt_r <= frame_cnt_r + 5'h01; // R07
		end
	end

	// Register images; reserved bits other than the transfer field read as zero
	always @* begin
		xfer2_img = 24'h000000; // R20
		xfer2_img[`TOFR_XFER2_CNT_MSB:`TOFR_XFER2_CNT_LSB] = xfer2_cnt_r;
		xfer2_img[`TOFR_XFER2_RSV_MSB:`TOFR_XFER2_RSV_LSB] = xfer2_rsv_r;
	end

	// Read format image
	always @* begin
		rdfmt_img = `TOFR_RDFMT_RST; // R20
		rdfmt_img[`TOFR_RDFMT_ALIGN_MSB:`TOFR_RDFMT_ALIGN_LSB] = align_r;
		rdfmt_img[`TOFR_RDFMT_BSEL_MSB:`TOFR_RDFMT_BSEL_LSB] = bsel_r;
		rdfmt_img[`TOFR_RDFMT_CNT1_MSB:`TOFR_RDFMT_CNT1_LSB] = cnt1_r;
		rdfmt_img[`TOFR_RDFMT_WBYTE_MSB:`TOFR_RDFMT_WBYTE_LSB] = wbyte_r;
	end

	// Phase image with the low counter bit
	always @* begin
		phase_img = `TOFR_RESULT_RST;
		phase_img[`TOFR_PH_CNT0] = frame_cnt_r[0]; // R07
		phase_img[`TOFR_PH_AMBOVL] = amb_ovl_r; // R08
		phase_img[`TOFR_PH_MODF] = modf_r; // R09
		phase_img[`TOFR_PH_VALID] = valid_r; // R10
		phase_img[`TOFR_PH_CH_MSB:`TOFR_PH_CH_LSB] = chan_r; // R11
		phase_img[`TOFR_PH_DRIVE] = drive_r; // R12
		phase_img[`TOFR_PH_OVF] = phase_ovf_r; // R13
		phase_img[15:0] = phase_r; // R13
	end

	// Amplitude image with the middle counter bits
	always @* begin
		amp_img = `TOFR_RESULT_RST;
		amp_img[`TOFR_AMP_BIN_MSB:`TOFR_AMP_BIN_LSB] = bin_r; // R14
		amp_img[`TOFR_AMP_F2WRAP] = f2wrap_r; // R15
		amp_img[`TOFR_AMP_SIGOVL] = sigovl_r; // R16
		amp_img[`TOFR_AMP_CNT_MSB:`TOFR_AMP_CNT_LSB] = frame_cnt_r[2:1]; // R07
		amp_img[15:0] = amp_r; // R17
	end

	// Temperature image with the high counter bits
	always @* begin
		temp_img = `TOFR_RESULT_RST;
		temp_img[`TOFR_TMP_DIE_MSB:`TOFR_TMP_DIE_LSB] = die_r; // R18
		temp_img[`TOFR_TMP_AMB_MSB:`TOFR_TMP_AMB_LSB] = amb_r; // R19
		temp_img[`TOFR_TMP_CNT_MSB:`TOFR_TMP_CNT_LSB] = frame_cnt_r[4:3]; // R07
	end

	// Read mux; unmapped offsets return zero
	always @* begin
		rdata_nxt = 24'h000000;
		if (hit(reg_addr, `TOFR_OFF_XFER2)) begin
			rdata_nxt = xfer2_img;
		end else if (hit(reg_addr, `TOFR_OFF_RDFMT)) begin
			rdata_nxt = rdfmt_img;
		end else if (hit(reg_addr, `TOFR_OFF_PHASE)) begin
			rdata_nxt = phase_img;
		end else if (hit(reg_addr, `TOFR_OFF_AMP)) begin
			rdata_nxt = amp_img;
		end else if (hit(reg_addr, `TOFR_OFF_TEMP)) begin
			rdata_nxt = temp_img;
		end
	end

	// Data captured with the strobe and held until the next read
	always @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 24'h000000;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

endmodule
`default_nettype wire

// >>> tofr_regs_sva.sv
// Checker for the result and host-engine register bank
`timescale 1ns/1ps
`default_nettype none
module tofr_regs_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata,
	// Host engine controls
	input wire logic [1:0] first_xfer_byte_count,
	input wire logic [1:0] second_xfer_byte_count,
	input wire logic xfer_count_error,
	input wire logic [7:0] host_second_write_byte,
	// Frame results
	input wire logic frame_done,
	input wire logic [15:0] frame_phase,
	input wire logic frame_phase_wrap,
	input wire logic [15:0] signal_amplitude,
	input wire logic [11:0] die_temperature_code,
	input wire logic [9:0] ambient_level_code,
	input wire logic [9:0] ambient_calibration_point,
	input wire logic [9:0] ambient_saturation_threshold
);
	// Own copy of the last frame, so reads of any age can be judged
	logic [16:0] ph_r;
	logic [15:0] amp_r;
	logic [21:0] tmp_r;
	logic ovl_r;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ph_r <= 17'h0;
			amp_r <= 16'h0;
			tmp_r <= 22'h0;
			ovl_r <= 1'b0;
		end else if (frame_done) begin
			ph_r <= {frame_phase_wrap, frame_phase};
			amp_r <= signal_amplitude;
			tmp_r <= {die_temperature_code, ambient_level_code};
			ovl_r <= ambient_level_code > ambient_calibration_point &&
				ambient_level_code - ambient_calibration_point > ambient_saturation_threshold;
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	AST_CNT2_TWO: assert property (reg_wr && reg_addr == 8'h05 && reg_wdata[23:22] == 2'h1 ##1 !reg_wr |=>
		second_xfer_byte_count == 2'h2) else $error("second count not two");
	AST_CNT2_BAD: assert property (reg_wr && reg_addr == 8'h05 && reg_wdata[23] ##1 !reg_wr |=>
		second_xfer_byte_count == 2'h1 && xfer_count_error) else $error("bad count not flagged");
	AST_CNT1_TWO: assert property (reg_wr && reg_addr == 8'h07 && reg_wdata[17:16] == 2'h1 ##1 !reg_wr |=>
		first_xfer_byte_count == 2'h2) else $error("first count not two");
	AST_WBYTE: assert property (reg_wr && reg_addr == 8'h07 ##1 !reg_wr |=>
		host_second_write_byte == $past(reg_wdata[7:0], 2)) else $error("write byte wrong");
	AST_PHASE: assert property (reg_rd && !frame_done && reg_addr == 8'h08 |=>
		reg_rdata[16:0] == ph_r) else $error("phase image wrong");
	AST_AMB_OVL: assert property (reg_rd && !frame_done && reg_addr == 8'h08 |=>
		reg_rdata[22] == ovl_r) else $error("ambient overload wrong");
	AST_AMP: assert property (reg_rd && !frame_done && reg_addr == 8'h09 |=>
		reg_rdata[15:0] == amp_r) else $error("amplitude image wrong");
	AST_TEMP: assert property (reg_rd && !frame_done && reg_addr == 8'h0A |=>
		reg_rdata[23:2] == tmp_r) else $error("temperature image wrong");
	COV_B2B: cover property (frame_done ##1 frame_done);
	COV_BAD: cover property (xfer_count_error);
	COV_OVL: cover property (ovl_r);
endmodule
bind tofr_regs tofr_regs_sva u_tofr_regs_sva (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .first_xfer_byte_count, .second_xfer_byte_count, .xfer_count_error, .host_second_write_byte,
	.frame_done, .frame_phase, .frame_phase_wrap, .signal_amplitude, .die_temperature_code,
	.ambient_level_code, .ambient_calibration_point, .ambient_saturation_threshold);
`default_nettype wire

// >>> tofr_host_model.sv
// Register port host issuing strobed reads and writes
`timescale 1ns/1ps
`default_nettype none
module tofr_host_model (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] reg_addr,
	output logic [23:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [23:0] reg_rdata,
	input wire logic reg_rd_valid
);
	initial begin
		reg_addr = 8'hFF;
		reg_wdata = 24'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		if (a == 8'h05) reg_wdata[21:0] = 22'h080000;
		if (a == 8'h07) reg_wdata[15:8] = 8'h00;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		int n;
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rd_valid !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		d = (reg_rd_valid === 1'b1) ? reg_rdata : 24'hxxxxxx;
	endtask
endmodule
`default_nettype wire

// >>> tb_tofr_regs.sv
// Self-checking bench for the result and host-engine register bank
`timescale 1ns/1ps
`default_nettype none
module tb_tofr_regs;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rd_valid, xfer_count_error, ext_temp_cfg_error;
	logic [1:0] first_xfer_byte_count, second_xfer_byte_count;
	logic [7:0] host_second_write_byte, host_read_byte;
	logic [11:0] ext_temp_value;
	logic ext_temp_wide_enable = 1'b0;
	logic frame_done = 1'b0;
	logic [9:0] ambient_calibration_point = 10'h100, ambient_saturation_threshold = 10'h040;
	logic [9:0] ambient_level_code = 10'h0;
	logic [31:0] host_read_word = 32'h0;
	logic [15:0] s = 16'h0;
	logic [4:0] fc = 5'h0;
	logic [7:0] offs [5] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h06};
	int num_errors = 0, checks_done = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys;
	tofr_host_model u_tofr_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid);
	tofr_regs u_tofr_regs (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid,
		.ext_temp_wide_enable, .ambient_calibration_point, .ambient_saturation_threshold,
		.first_xfer_byte_count, .second_xfer_byte_count, .xfer_count_error, .host_second_write_byte,
		.host_read_word, .host_read_byte, .ext_temp_value, .ext_temp_cfg_error, .frame_done,
		.frame_phase(s), .frame_phase_wrap(s[0]), .second_freq_phase_wrap(s[1]), .signal_amplitude(~s),
		.signal_overload_flag(s[2]), .range_bin_index(s[7:4]), .modulation_freq_sel(s[3]),
		.internal_leak_cal_frame(s[8]), .emitter_leak_cal_frame(s[9]), .emitter_channel(s[11:10]),
		.drive_current_level(s[12]), .die_temperature_code(s[15:4]), .ambient_level_code);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic t_reset_values;
		logic [23:0] d;
		chk({first_xfer_byte_count, second_xfer_byte_count}, 4'h5);
		u_tofr_host_model.rd(8'h05, d);
		chk(d, 24'h080000);
		foreach (offs[i]) begin
			u_tofr_host_model.rd(offs[i], d);
			chk(d, 24'h0);
		end
	endtask
	task automatic t_counts;
		logic [23:0] d;
		for (int c = 0; c < 4; c++) begin
			u_tofr_host_model.wr(8'h05, {c[1:0], 22'h0});
			u_tofr_host_model.wr(8'h07, {6'h0, c[1:0], 8'h0, 8'h5A ^ 8'(c)});
			@(posedge clk_sys);
			#1;
			chk(second_xfer_byte_count, c < 2 ? c + 1 : 1);
			chk(first_xfer_byte_count, c < 2 ? c + 1 : 1);
			chk(xfer_count_error, c > 1);
			chk(host_second_write_byte, 8'h5A ^ 8'(c));
			u_tofr_host_model.rd(8'h05, d);
			chk(d, {c[1:0], 22'h080000});
		end
	endtask
	task automatic t_route;
		host_read_word = 32'hA1B2C3D4;
		ext_temp_wide_enable = 1'b1;
		for (int k = 0; k < 4; k++) begin
			u_tofr_host_model.wr(8'h07, {4'h8, k[1:0], 18'h0});
			repeat (2) @(posedge clk_sys);
			#1;
			chk(host_read_byte, host_read_word[8*k +: 8]);
			chk({ext_temp_cfg_error, ext_temp_value}, 13'h0C3D);
		end
		u_tofr_host_model.wr(8'h07, 24'h0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(ext_temp_cfg_error, 1'b1);
		ext_temp_wide_enable = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({ext_temp_cfg_error, ext_temp_value}, 13'h00D4);
	endtask
	task automatic frame(input logic [15:0] v, input logic [9:0] a);
		@(posedge clk_sys);
		#1;
		s = v;
		ambient_level_code = a;
		frame_done = 1'b1;
		@(posedge clk_sys);
		#1;
		frame_done = 1'b0;
		fc++;
	endtask
	task automatic check_frame(input logic ovl);
		logic [23:0] d;
		u_tofr_host_model.rd(8'h08, d);
		chk(d[23:20], {fc[0], ovl, s[3], ~(s[8] | s[9])});
		chk(d[19:0], {s[11:10], s[12], s[0], s});
		u_tofr_host_model.rd(8'h09, d);
		chk(d, {s[7:4], s[1], s[2], fc[2:1], ~s});
		u_tofr_host_model.rd(8'h0A, d);
		chk(d, {s[15:4], ambient_level_code, fc[4:3]});
	endtask
	task automatic t_frames;
		frame(16'h5A3C, 10'h0F0);
		check_frame(1'b0);
		frame(16'hA5C3, 10'h140);
		check_frame(1'b0);
		frame(16'h1CF7, 10'h141);
		check_frame(1'b1);
		// Results are read-only, a write must leave them alone
		u_tofr_host_model.wr(8'h08, 24'hFFFFFF);
		check_frame(1'b1);
	endtask
	task automatic t_wrap;
		@(posedge clk_sys);
		#1;
		frame_done = 1'b1;
		for (int i = 0; i < 31; i++) begin
			s = 16'((30 - i) * 16'h0421);
			@(posedge clk_sys);
			#1;
			fc++;
		end
		frame_done = 1'b0;
		check_frame(1'b1);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		t_reset_values;
		t_counts;
		t_route;
		t_frames;
		t_wrap;
		report_and_stop;
	end
endmodule
`default_nettype wire
